// *** core/fspc_ctrl.sv ***
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Operation
// - boot fuse selects reset vector address
// - no processor path changes fuse values
// - ready irq while store enable clear
// - busy set on section op, blocks access
// - busy clears on reenable or load
// - reserved bit five reads zero
// - reenable section when no operation running
// - reenable during loading discards buffer
// - lock set programs lock from low data
// - lpm within three cycles reads lock/fuse
// - page write from buffer to page
// - page erase of addressed page
// - command bits clear on finish or timeout
// - halt cpu for no-rww section ops
// - plain store loads buffer word
// - store enable four cycle window
// - only five command patterns accepted
// - target address latched at start
// - buffer words load in any order
// - lpm addresses flash byte-wise via z0
// - buffer clears on write, reenable, reset
// - eeprom write blocks programming, fuse reads
module fspc_ctrl
	import fspc_pkg::*;
#(
	parameter int PAGE_WORDS = 64,
	parameter int WORD_BITS = 6,
	parameter logic [15:0] RWW_LIMIT_WORD = 16'h1C00,
	parameter logic [15:0] BOOT_RESET_WORD = 16'h1C00
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire fspc_bus_s bus,
	output logic [7:0] rdata,
	input wire logic store_instr,
	input wire logic load_instr,
	output logic [7:0] load_data,
	output logic load_override,
	input wire logic [7:0] flash_byte,
	input wire logic global_irq_enable,
	output logic store_ready_irq,
	input wire logic eeprom_busy,
	input wire logic boot_reset_fuse,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] fuse_high,
	input wire logic [7:0] fuse_ext,
	input wire logic [7:0] lock_bits_in,
	output logic [15:0] reset_vector,
	output logic section_blocked,
	output logic cpu_halt,
	output fspc_flash_s flash_cmd,
	input wire logic flash_done
);
	typedef struct packed {
		fspc_state_e st;
		logic irq_en;
		logic busy;
		logic [4:0] cmd;
		logic [2:0] win;
		logic [2:0] rwin;
		logic halt;
		logic loading;
		logic [15:0] zptr;
		logic [7:0] dlo;
		logic [7:0] dhi;
		logic [PAGE_WORDS-1:0] filled;
		logic [7:0] rdata;
		logic [7:0] ldata;
		logic lovr;
		fspc_flash_s fc;
	} fspc_regs_s;

	logic [15:0] buffer [PAGE_WORDS];
	fspc_regs_s r, next_r;
	logic [4:0] wcmd;
	logic [WORD_BITS-1:0] widx;
	logic do_store;
	logic do_load;

	localparam logic [1:0] KIND_ERASE = 2'h0;
	localparam logic [1:0] KIND_WRITE = 2'h1;
	localparam logic [1:0] KIND_LOCK = 2'h2;

	function automatic logic in_rww(input logic [15:0] word_addr);
		in_rww = word_addr < RWW_LIMIT_WORD;
	endfunction

	// low two pointer bits pick the byte handed back instead of flash contents
	function automatic logic [7:0] fuse_pick(input logic [1:0] sel, input logic [7:0] f_lo,
		input logic [7:0] f_lock, input logic [7:0] f_ext, input logic [7:0] f_hi);
		unique case (sel)
			2'h0: fuse_pick = f_lo;
			2'h1: fuse_pick = f_lock;
			2'h2: fuse_pick = f_ext;
			default: fuse_pick = f_hi;
		endcase
	endfunction

	assign wcmd = bus.wdata[4:0];
	assign widx = r.zptr[WORD_BITS:1];
	assign do_store = store_instr && r.st == FSPC_ARMED && r.cmd == CMD_LOAD && !eeprom_busy;
	assign reset_vector = boot_reset_fuse ? APP_RESET_WORD : BOOT_RESET_WORD;
	assign store_ready_irq = r.irq_en && global_irq_enable && !r.cmd[0];
	assign section_blocked = r.busy;
	assign cpu_halt = r.halt;
	assign rdata = r.rdata;
	assign load_data = r.ldata;
	assign load_override = r.lovr;
	assign flash_cmd = r.fc;

	always_comb begin
		next_r = r;
		next_r.fc.req = 1'b0;
		next_r.lovr = 1'b0;
		next_r.ldata = flash_byte;
		next_r.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				CTRL_ADDR: next_r.rdata = {r.irq_en, r.busy, 1'b0, r.cmd};
				PTR_LO_ADDR: next_r.rdata = r.zptr[7:0];
				PTR_HI_ADDR: next_r.rdata = r.zptr[15:8];
				DATA_LO_ADDR: next_r.rdata = r.dlo;
				DATA_HI_ADDR: next_r.rdata = r.dhi;
				default: next_r.rdata = 8'h00;
			endcase
		end
		if (bus.wr) begin
			unique case (bus.addr)
				PTR_LO_ADDR: next_r.zptr[7:0] = bus.wdata;
				PTR_HI_ADDR: next_r.zptr[15:8] = bus.wdata;
				DATA_LO_ADDR: next_r.dlo = bus.wdata;
				DATA_HI_ADDR: next_r.dhi = bus.wdata;
				default: ;
			endcase
		end
		// fuse registers are inputs only: no write reaches them
		unique case (r.st)
			FSPC_IDLE: begin
				if (bus.wr && bus.addr == CTRL_ADDR) begin
					next_r.irq_en = bus.wdata[CTRL_BIT_IRQ_EN];
					if (!eeprom_busy && (wcmd == CMD_REENABLE || wcmd == CMD_LOCK
						|| wcmd == CMD_PWRITE || wcmd == CMD_PERASE
						|| wcmd == CMD_LOAD)) begin
						next_r.cmd = wcmd;
						next_r.st = FSPC_ARMED;
						next_r.win = 3'(STORE_WIN);
						next_r.rwin = 3'(READ_WIN);
						if (wcmd == CMD_REENABLE && r.loading) begin
							next_r.filled = '0;
							next_r.loading = 1'b0;
						end
					end
				end
			end
			FSPC_ARMED: begin
				if (bus.wr && bus.addr == CTRL_ADDR) begin
					next_r.irq_en = bus.wdata[CTRL_BIT_IRQ_EN];
				end
				if (r.rwin != 3'h0) begin
					next_r.rwin = r.rwin - 3'h1;
				end
				if (load_instr && r.cmd == CMD_LOCK && r.rwin != 3'h0 && !eeprom_busy) begin
					next_r.lovr = 1'b1;
					next_r.ldata = fuse_pick(r.zptr[1:0], fuse_low, lock_bits_in, fuse_ext,
						fuse_high);
					next_r.cmd = '0;
					next_r.st = FSPC_IDLE;
				end else if (store_instr && !eeprom_busy) begin
					next_r.cmd = '0;
					next_r.st = FSPC_IDLE;
					unique case (r.cmd)
						CMD_LOAD: begin
							next_r.busy = 1'b0;
							next_r.loading = 1'b1;
							next_r.filled[widx] = 1'b1;
						end
						CMD_REENABLE: begin
							next_r.busy = 1'b0;
							next_r.filled = '0;
						end
						CMD_LOCK: begin
							next_r.fc.req = 1'b1;
							next_r.fc.kind = KIND_LOCK;
							next_r.fc.data = {8'h00, r.dlo | LOCK_KEEP_MASK};
							next_r.cmd = r.cmd;
							next_r.st = FSPC_BUSY;
						end
						default: begin
							next_r.fc.req = 1'b1;
							next_r.fc.kind = r.cmd == CMD_PWRITE ? KIND_WRITE : KIND_ERASE;
							// page base word: byte bit and word-in-page bits drop out
							next_r.fc.word_addr = {1'b0, r.zptr[15:WORD_BITS+1],
								{WORD_BITS{1'b0}}};
							next_r.cmd = r.cmd;
							next_r.st = FSPC_BUSY;
							if (in_rww(r.zptr >> 1)) begin
								next_r.busy = 1'b1;
							end else begin
								next_r.halt = 1'b1;
							end
						end
					endcase
				end else if (r.win == 3'h1) begin
					next_r.cmd = '0;
					next_r.st = FSPC_IDLE;
				end else begin
					next_r.win = r.win - 3'h1;
				end
			end
			FSPC_BUSY: begin
				if (bus.wr && bus.addr == CTRL_ADDR) begin
					next_r.irq_en = bus.wdata[CTRL_BIT_IRQ_EN];
				end
				if (flash_done) begin
					next_r.cmd = '0;
					next_r.halt = 1'b0;
					next_r.st = FSPC_IDLE;
					if (r.cmd == CMD_PWRITE) begin
						next_r.filled = '0;
						next_r.loading = 1'b0;
					end
				end
			end
			default: next_r.st = FSPC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// buffer storage; validity tracked by the filled bits, so no reset needed
	always_ff @(posedge clk_sys) begin
		if (do_store) begin
			buffer[widx] <= {r.dhi, r.dlo};
		end
	end

	a_store_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r.st == FSPC_ARMED && !store_instr && !load_instr)[*4] |=> r.st != FSPC_ARMED)
		else $error("store enable outlived its window");
	a_bad_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r.st == FSPC_IDLE && bus.wr && bus.addr == CTRL_ADDR && bus.wdata[4:0] == 5'h07)
		|=> r.st == FSPC_IDLE)
		else $error("illegal command pattern accepted");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		store_ready_irq == (r.irq_en && global_irq_enable && r.st == FSPC_IDLE))
		else $error("ready interrupt wrong");
	a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(bus.rd) && $past(bus.addr) == CTRL_ADDR |-> !rdata[CTRL_BIT_RSVD])
		else $error("reserved bit read as one");
	a_busy_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.busy && r.st == FSPC_BUSY |=> r.busy)
		else $error("busy dropped during operation");
	a_addr_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_BUSY && $past(r.st) == FSPC_BUSY |-> $stable(r.fc.word_addr))
		else $error("target address changed");
	a_eeprom_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
		eeprom_busy |=> !r.fc.req && !r.lovr)
		else $error("programming during eeprom write");
	a_halt_scope: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.halt |-> r.st == FSPC_BUSY && !r.busy)
		else $error("halt outside no-rww operation");
	a_reset_vec: assert property (@(posedge clk_sys) disable iff (!rst_n)
		boot_reset_fuse |-> reset_vector == APP_RESET_WORD)
		else $error("reset vector wrong");

	a_vec_boot: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!boot_reset_fuse |-> reset_vector == BOOT_RESET_WORD)
		else $error("boot reset vector wrong");

	a_irq_global: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!global_irq_enable |-> !store_ready_irq)
		else $error("ready interrupt without global enable");

	a_busy_set_rww: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_ARMED && store_instr && !eeprom_busy && !load_instr
		&& (r.cmd == CMD_PERASE || r.cmd == CMD_PWRITE) && in_rww(r.zptr >> 1) |=> r.busy)
		else $error("busy not set for section operation");

	a_halt_no_read_while_write_section: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_ARMED && store_instr && !eeprom_busy && !load_instr
		&& (r.cmd == CMD_PERASE || r.cmd == CMD_PWRITE) && !in_rww(r.zptr >> 1) |=> r.halt)
		else $error("cpu not halted for no-rww operation");

	a_load_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_ARMED && store_instr && !eeprom_busy && r.cmd == CMD_LOAD |=> !r.busy)
		else $error("busy kept after buffer load");

	a_reenable_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_IDLE && bus.wr && bus.addr == CTRL_ADDR && bus.wdata[4:0] == CMD_REENABLE
		&& !eeprom_busy && r.loading |=> r.filled == '0)
		else $error("buffer kept after reenable during load");

	a_buffer_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_BUSY && flash_done && r.cmd == CMD_PWRITE |=> r.filled == '0)
		else $error("buffer kept after page write");

	// bits outside the boot lock field must never be programmed
	a_lock_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.fc.req && r.fc.kind == KIND_LOCK
		|-> (r.fc.data[7:0] & LOCK_KEEP_MASK) == LOCK_KEEP_MASK)
		else $error("lock write touched kept bits");

	a_read_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_ARMED && r.rwin == 3'h0 |=> !r.lovr)
		else $error("fuse read after its window");

	a_enable_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_BUSY |-> r.cmd[0])
		else $error("store enable dropped during operation");

	a_page_base: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.fc.req && r.fc.kind != KIND_LOCK |-> r.fc.word_addr[WORD_BITS-1:0] == '0)
		else $error("page address not page aligned");

	a_buffer_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		do_store |=> buffer[$past(widx)] == $past({r.dhi, r.dlo}))
		else $error("buffer word not stored");

	a_lock_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.lovr |-> r.st == FSPC_IDLE)
		else $error("fuse read left command armed");

	a_eeprom_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		eeprom_busy && r.st == FSPC_IDLE |=> r.st == FSPC_IDLE)
		else $error("command accepted during eeprom write");

	a_win_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_ARMED && r.win == 3'h1 && !store_instr && !load_instr
		|=> r.st == FSPC_IDLE)
		else $error("command outlived its window");

	a_done_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_BUSY && flash_done |=> r.st == FSPC_IDLE && !r.halt && r.cmd == '0)
		else $error("operation not released on done");

	a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == FSPC_IDLE |=> !r.fc.req)
		else $error("flash request without store");
endmodule

// *** core/fspc_pkg.sv ***
package fspc_pkg;
	localparam int CTRL_BIT_IRQ_EN = 7;
	localparam int CTRL_BIT_BUSY = 6;
	localparam int CTRL_BIT_RSVD = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] PTR_LO_ADDR = 4'h1;
	localparam logic [3:0] PTR_HI_ADDR = 4'h2;
	localparam logic [3:0] DATA_LO_ADDR = 4'h3;
	localparam logic [3:0] DATA_HI_ADDR = 4'h4;
	localparam logic [4:0] CMD_REENABLE = 5'h11;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_PWRITE = 5'h05;
	localparam logic [4:0] CMD_PERASE = 5'h03;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam int STORE_WIN = 4;
	localparam int READ_WIN = 3;
	localparam logic [15:0] APP_RESET_WORD = 16'h0000;
	localparam logic [7:0] LOCK_KEEP_MASK = 8'hC3;
	typedef enum logic [1:0] {
		FSPC_IDLE = 2'b00,
		FSPC_ARMED = 2'b01,
		FSPC_BUSY = 2'b11
	} fspc_state_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fspc_bus_s;
	typedef struct packed {
		logic req;
		logic [1:0] kind;
		logic [15:0] word_addr;
		logic [15:0] data;
	} fspc_flash_s;
endpackage

// *** sim/fspc_flash_model.sv ***
`timescale 1ns/1ps
module fspc_flash_model
	import fspc_pkg::*;
#(
	parameter int DELAY = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire fspc_flash_s flash_cmd,
	output logic flash_done,
	output logic [7:0] flash_byte
);
	int cnt;
	// the array byte is negated every cycle, so from its reset value of zero it never changes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			flash_done <= 1'b0;
			flash_byte <= 8'h00;
		end else begin
			flash_byte <= ~flash_byte + 8'h01;
			flash_done <= (cnt == 1);
			if (flash_cmd.req) begin
				cnt <= DELAY;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// *** sim/flash_self_program_control_test.sv ***
`timescale 1ns/1ps
module flash_self_program_control_test;
	import fspc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	fspc_bus_s bus = '0;
	logic store_instr = 1'b0;
	logic load_instr = 1'b0;
	logic global_irq_enable = 1'b1;
	logic eeprom_busy = 1'b0;
	logic boot_reset_fuse = 1'b1;
	logic [7:0] fz [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] rdata, load_data, flash_byte;
	logic [7:0] lfsr = 8'h58;
	logic load_override, store_ready_irq, section_blocked, cpu_halt, flash_done;
	logic [15:0] reset_vector;
	fspc_flash_s flash_cmd, seen_cmd;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #4 clk_sys = ~clk_sys;
	fspc_ctrl i_dut (.clk_sys, .rst_n, .bus, .rdata, .store_instr, .load_instr, .load_data,
		.load_override, .flash_byte, .global_irq_enable, .store_ready_irq, .eeprom_busy,
		.boot_reset_fuse, .fuse_low(fz[0]), .lock_bits_in(fz[1]), .fuse_ext(fz[2]),
		.fuse_high(fz[3]), .reset_vector, .section_blocked, .cpu_halt, .flash_cmd, .flash_done);
	fspc_flash_model i_flash (.clk_sys, .rst_n, .flash_cmd, .flash_done, .flash_byte);
	always @(posedge clk_sys) begin
		if (flash_cmd.req) begin
			seen_cmd <= flash_cmd;
		end
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done;
		end
	end
	function automatic logic [7:0] next_rand(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys) bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic instr(input bit ld);
		@(posedge clk_sys) {load_instr, store_instr} <= {ld, !ld};
		@(posedge clk_sys) {load_instr, store_instr} <= 2'b00;
		#1;
	endtask
	task automatic wait_idle(output logic [7:0] d);
		for (int i = 0; i < 40; i++) begin
			rd(CTRL_ADDR, d);
			if (d[0] === 1'b0) break;
		end
	endtask
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] d;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		boot_reset_fuse <= 1'b0;
		check("vector_app", reset_vector, APP_RESET_WORD);
		@(posedge clk_sys) #1 check("vector_boot", reset_vector, 16'h1C00);
		boot_reset_fuse <= 1'b1;
		rd(CTRL_ADDR, d);
		check("ctrl_reset", d, CTRL_RESET);
		wr(CTRL_ADDR, 8'hFF);
		rd(CTRL_ADDR, d);
		check("ctrl_illegal", d, 8'h80);
		check("irq_idle", store_ready_irq, 1'b1);
		global_irq_enable <= 1'b0;
		#1 check("irq_global", store_ready_irq, 1'b0);
		global_irq_enable <= 1'b1;
		wr(CTRL_ADDR, 8'h87);
		rd(CTRL_ADDR, d);
		check("ctrl_illegal7", d, 8'h80);
		eeprom_busy <= 1'b1;
		wr(CTRL_ADDR, 8'h81);
		rd(CTRL_ADDR, d);
		check("ctrl_eeprom", d, 8'h80);
		eeprom_busy <= 1'b0;
		wr(CTRL_ADDR, 8'h85);
		#1 check("irq_armed", store_ready_irq, 1'b0);
		repeat (6) @(posedge clk_sys);
		rd(CTRL_ADDR, d);
		check("ctrl_timeout", d, 8'h80);
		$display("test basic finished");
		for (int i = 0; i < 4; i++) begin
			lfsr = next_rand(lfsr);
			fz[i] <= lfsr;
			wr(PTR_LO_ADDR, 8'(i));
			wr(CTRL_ADDR, CMD_LOCK);
			instr(1'b1);
			check("readback", {load_override, load_data}, {1'b1, lfsr});
		end
		$display("test readback finished");
		// same page for erase and write, erased before written
		wr(PTR_LO_ADDR, 8'h3E);
		wr(PTR_HI_ADDR, 8'h10);
		rd(PTR_HI_ADDR, d);
		check("ptr_hi", d, 8'h10);
		wr(CTRL_ADDR, CMD_PERASE);
		instr(1'b0);
		check("rww_flags", {section_blocked, cpu_halt}, 2'b10);
		rd(CTRL_ADDR, d);
		check("ctrl_busy", d & 8'h41, 8'h41);
		check("erase_cmd", {seen_cmd.kind, seen_cmd.word_addr[13:0]}, 16'h0800);
		wait_idle(d);
		check("ctrl_done", d, 8'h40);
		wr(DATA_LO_ADDR, lfsr);
		wr(CTRL_ADDR, CMD_LOAD);
		instr(1'b0);
		rd(CTRL_ADDR, d);
		check("load_clears", d, 8'h00);
		wr(CTRL_ADDR, CMD_PWRITE);
		instr(1'b0);
		wr(PTR_HI_ADDR, 8'h00);
		check("write_cmd", {seen_cmd.kind, seen_cmd.word_addr[13:0]}, 16'h4800);
		wait_idle(d);
		wr(CTRL_ADDR, CMD_REENABLE);
		instr(1'b0);
		rd(CTRL_ADDR, d);
		check("reenable", {section_blocked, d}, 9'h000);
		$display("test rww finished");
		wr(PTR_HI_ADDR, 8'h3C);
		wr(CTRL_ADDR, CMD_PERASE);
		instr(1'b0);
		check("no_read_while_write_section_flags", {section_blocked, cpu_halt}, 2'b01);
		wait_idle(d);
		check("halt_end", cpu_halt, 1'b0);
		lfsr = next_rand(lfsr);
		wr(DATA_LO_ADDR, lfsr);
		wr(CTRL_ADDR, CMD_LOCK);
		instr(1'b0);
		@(posedge clk_sys) #1 check("lock_cmd", {seen_cmd.kind, seen_cmd.data[5:2]}, {2'd2, lfsr[5:2]});
		wait_idle(d);
		$display("test no_read_while_write_section finished");
		test_done;
	end
endmodule
